/* src/seg_pkg.sv */
package seg_pkg;
    // Frame lengths checked at the fall of select
    localparam logic [4:0] BYTE_FRAME_LEN = 5'h12;   // 18 pulses
    localparam logic [4:0] WORD_FRAME_LEN = 5'h19;   // 25 pulses
    localparam int         BYTE_ADDR_W    = 7;
    localparam int         WORD_ADDR_W    = 6;
    localparam int         ARRAY_DEPTH    = 128;
    // Erased array content
    localparam logic [7:0] ERASED_BYTE    = 8'hFF;
    // Opcodes
    localparam logic [1:0] OP_EXT         = 2'h0;
    localparam logic [1:0] OP_WRITE       = 2'h1;
    localparam logic [1:0] OP_READ        = 2'h2;
    localparam logic [1:0] OP_ERASE       = 2'h3;
    // Extended sub-codes in the leading address bits
    localparam logic [1:0] SUB_DISABLE    = 2'h0;
    localparam logic [1:0] SUB_FILL_ALL   = 2'h1;
    localparam logic [1:0] SUB_ERASE_ALL  = 2'h2;
    localparam logic [1:0] SUB_ENABLE     = 2'h3;
    // Self-timed programming cycle, in microseconds and cycles at 25 MHz
    localparam int         PROG_TIME_US   = 5000;
    localparam int         CLK_MHZ        = 25;
    localparam int         PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
    // Frame decoder states
    typedef enum logic [2:0] {
        SEG_IDLE, SEG_OPCODE, SEG_ADDR, SEG_DATA, SEG_READ, SEG_IGNORE
    } seg_state_e;
endpackage : seg_pkg

/* src/seg_count_if.sv */
`timescale 1ns/1ps
// Pulse counter link between frame decoder and guard
interface seg_count_if;
    logic       clear;     // Restart count
    logic       pulse;     // One serial clock rising edge
    logic [4:0] count;     // Pulses since start bit
    logic       word_org;  // Word organisation selected
    logic       frame_ok;  // Count matches frame length
    modport ctrl  (output clear, output pulse, output word_org,
                   input count, input frame_ok);
    modport guard (input clear, input pulse, input word_org,
                   output count, output frame_ok);
endinterface : seg_count_if

/* src/seg_pulse_guard.sv */
`timescale 1ns/1ps
// Counts serial clock pulses per frame and checks the frame length
module seg_pulse_guard (
    input  wire logic clk,
    input  wire logic rst_n,
    seg_count_if.guard cnt
);
    logic [4:0] count_q;   // Saturating pulse count
    logic [4:0] count_d;
    logic [4:0] want_len;  // Length for the chosen organisation

    // Saturate so a glitch storm cannot wrap back to a legal value
    // A start pulse clears and counts itself as pulse one
    assign count_d = cnt.clear ? {4'h0, cnt.pulse} :
                     (cnt.pulse && count_q != 5'h1F) ? count_q + 5'h01 :
                     count_q;
    assign want_len = cnt.word_org ? seg_pkg::WORD_FRAME_LEN
                                   : seg_pkg::BYTE_FRAME_LEN;
    assign cnt.count    = count_q;
    assign cnt.frame_ok = (count_q == want_len);

    // Counter register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 5'h00;
        end else begin
            count_q <= count_d;
        end
    end

    count_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        cnt.clear |=> count_q == {4'h0, $past(cnt.pulse)})
        else $error("pulse count not cleared");
    count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cnt.pulse && !cnt.clear && count_q < 5'h1E)
        |=> count_q == $past(count_q) + 5'h01)
        else $error("pulse count did not step");
endmodule : seg_pulse_guard

/* src/seg_eeprom_guard.sv */
`timescale 1ns/1ps
// What this block does
// - Count serial clock pulses from start bit
// - Byte organisation writes need exactly 18 pulses
// - Wrong byte count abandons, array unchanged
// - Word organisation needs exactly 25 pulses
// - Count check gates only programming instructions
// - Array starts all ones
// - Select high then start one begins frame
// - Width select high gives word organisation
// - Opcode and sub-code decode
// - Select fall launches accepted programming cycle
module seg_eeprom_guard #(
    parameter int PROG_CYCLES = seg_pkg::PROG_CYCLES  // Shorten in sim
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic sel,        // Chip select pin
    input  wire logic sclk,       // Serial clock pin
    input  wire logic sdi,        // Serial data in pin
    input  wire logic org_n_byte, // Width select, high or open = word
    output logic      sdo,        // Serial data out
    output logic      sdo_oe,     // High while driving data out
    output logic      busy        // Programming cycle running
);
    seg_count_if cnt ();

    // Two-flop synchronisers for pins
    logic [1:0] sel_s_q, clk_s_q, dat_s_q, org_s_q;
    logic       clk_d1_q;     // Delayed synced clock for edges
    logic       sel_d1_q;     // Delayed synced select
    seg_pkg::seg_state_e st_q;
    logic [4:0] bits_q;       // Bits left in current field
    logic [1:0] op_q;         // Opcode
    logic [6:0] addr_q;       // Address
    logic [15:0] data_q;      // Data shift
    logic [15:0] rdsh_q;      // Read shift out
    logic       wen_q;        // Programming enabled
    logic       sdo_q;
    logic       oe_q;
    logic [20:0] prog_q;      // Programming cycle timer
    logic [7:0] mem_q [seg_pkg::ARRAY_DEPTH];

    wire s_sel  = sel_s_q[1];
    wire s_clk  = clk_s_q[1];
    wire s_dat  = dat_s_q[1];
    wire word   = org_s_q[1];
    wire rise   = s_clk & ~clk_d1_q;                // Clock rising edge
    wire fall_s = ~s_sel & sel_d1_q;                // Select falling
    wire start  = (st_q == seg_pkg::SEG_IDLE) & rise & s_dat & s_sel;
    wire [4:0] alen = word ? 5'(seg_pkg::WORD_ADDR_W)
                           : 5'(seg_pkg::BYTE_ADDR_W);
    wire [4:0] dlen = word ? 5'h10 : 5'h08;
    wire [1:0] sub  = word ? addr_q[5:4] : addr_q[6:5];
    wire is_prog = (op_q == seg_pkg::OP_WRITE) ||
                   (op_q == seg_pkg::OP_ERASE) ||
                   (op_q == seg_pkg::OP_EXT &&
                    (sub == seg_pkg::SUB_ERASE_ALL ||
                     sub == seg_pkg::SUB_FILL_ALL));
    wire done_frame = (st_q != seg_pkg::SEG_IDLE) &&
                      (st_q != seg_pkg::SEG_IGNORE);
    wire accept = fall_s & done_frame & is_prog & wen_q & cnt.frame_ok
                  & (prog_q == 21'h0);
    wire [6:0] widx = word ? {addr_q[5:0], 1'b0} : addr_q;
    wire [6:0] ridx = word ? {addr_q[5:0], 1'b0} : addr_q;

    assign cnt.clear    = ~s_sel | start;
    // Start bit edge is the first counted pulse
    assign cnt.pulse    = rise & s_sel
                          & (start | (st_q != seg_pkg::SEG_IDLE));
    assign cnt.word_org = word;
    assign busy   = (prog_q != 21'h0);
    assign sdo    = sdo_q;
    assign sdo_oe = oe_q;

    seg_pulse_guard u_guard (
        .clk   (clk),
        .rst_n (rst_n),
        .cnt   (cnt)
    );

    // Pin synchronisers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_s_q  <= 2'h0;
            clk_s_q  <= 2'h0;
            dat_s_q  <= 2'h0;
            org_s_q  <= 2'h3;
            clk_d1_q <= 1'b0;
            sel_d1_q <= 1'b0;
        end else begin
            sel_s_q  <= {sel_s_q[0], sel};
            clk_s_q  <= {clk_s_q[0], sclk};
            dat_s_q  <= {dat_s_q[0], sdi};
            org_s_q  <= {org_s_q[0], org_n_byte};
            clk_d1_q <= s_clk;
            sel_d1_q <= s_sel;
        end
    end

    // Frame decoder; a start bit is a one on a rising edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= seg_pkg::SEG_IDLE;
            bits_q <= 5'h00;
            op_q   <= 2'h0;
            addr_q <= 7'h00;
            data_q <= 16'h0000;
        end else if (!s_sel) begin
            st_q <= seg_pkg::SEG_IDLE;
        end else if (rise) begin
            case (st_q)
                seg_pkg::SEG_IDLE: begin
                    // Busy device ignores the bus
                    if (s_dat && prog_q == 21'h0) begin
                        st_q   <= seg_pkg::SEG_OPCODE;
                        bits_q <= 5'h02;
                    end
                end
                seg_pkg::SEG_OPCODE: begin
                    op_q   <= {op_q[0], s_dat};
                    bits_q <= bits_q - 5'h01;
                    if (bits_q == 5'h01) begin
                        st_q   <= seg_pkg::SEG_ADDR;
                        bits_q <= alen;
                    end
                end
                seg_pkg::SEG_ADDR: begin
                    addr_q <= {addr_q[5:0], s_dat};
                    bits_q <= bits_q - 5'h01;
                    if (bits_q == 5'h01) begin
                        bits_q <= dlen;
                        st_q   <= (op_q == seg_pkg::OP_READ)
                                  ? seg_pkg::SEG_READ : seg_pkg::SEG_DATA;
                    end
                end
                seg_pkg::SEG_DATA: begin
                    // Extra pulses keep counting and spoil the check
                    data_q <= {data_q[14:0], s_dat};
                end
                seg_pkg::SEG_READ: begin
                    st_q <= seg_pkg::SEG_READ;
                end
                default: st_q <= seg_pkg::SEG_IGNORE;
            endcase
        end
    end

    // Read output shift; driven low while busy and selected, otherwise only after the address, so the
    // host must already have released a shared wire
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sdo_q  <= 1'b1;
            oe_q   <= 1'b0;
            rdsh_q <= 16'hFFFF;
        end else if (!s_sel) begin
            oe_q  <= 1'b0;
            sdo_q <= 1'b1;
        end else if (prog_q != 21'h0) begin
            oe_q  <= 1'b1;
            sdo_q <= 1'b0;
        end else if (st_q == seg_pkg::SEG_ADDR && rise && bits_q == 5'h01
                     && op_q == seg_pkg::OP_READ) begin
            oe_q   <= 1'b1;
            sdo_q  <= 1'b0;
            rdsh_q <= word ? {mem_q[{addr_q[4:0], s_dat, 1'b0}],
                              mem_q[{addr_q[4:0], s_dat, 1'b1}]}
                           : {mem_q[{addr_q[5:0], s_dat}], 8'h00};
        end else if (st_q == seg_pkg::SEG_READ && rise) begin
            sdo_q  <= rdsh_q[15];
            rdsh_q <= {rdsh_q[14:0], 1'b1};
        end
    end

    // Enable state and programming timer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wen_q  <= 1'b0;
            prog_q <= 21'h0;
        end else begin
            if (fall_s && done_frame && op_q == seg_pkg::OP_EXT
                && cnt.count > 5'h02) begin
                if (sub == seg_pkg::SUB_ENABLE) begin
                    wen_q <= 1'b1;
                end else if (sub == seg_pkg::SUB_DISABLE) begin
                    wen_q <= 1'b0;
                end
            end
            if (accept) begin
                prog_q <= 21'(PROG_CYCLES);
            end else if (prog_q != 21'h0) begin
                prog_q <= prog_q - 21'h1;
            end
        end
    end

    // Array update on an accepted frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < seg_pkg::ARRAY_DEPTH; i++) begin
                mem_q[i] <= seg_pkg::ERASED_BYTE;
            end
        end else if (accept) begin
            for (int i = 0; i < seg_pkg::ARRAY_DEPTH; i++) begin
                if (op_q == seg_pkg::OP_EXT) begin
                    if (sub == seg_pkg::SUB_ERASE_ALL) begin
                        mem_q[i] <= seg_pkg::ERASED_BYTE;
                    end else begin
                        mem_q[i] <= mem_q[i] & (word ? ((i % 2 == 0)
                            ? data_q[15:8] : data_q[7:0]) : data_q[7:0]);
                    end
                end
            end
            if (op_q == seg_pkg::OP_WRITE || op_q == seg_pkg::OP_ERASE) begin
                if (word) begin
                    mem_q[widx] <= (op_q == seg_pkg::OP_ERASE)
                                   ? seg_pkg::ERASED_BYTE : data_q[15:8];
                    mem_q[widx | 7'h01] <= (op_q == seg_pkg::OP_ERASE)
                                   ? seg_pkg::ERASED_BYTE : data_q[7:0];
                end else begin
                    mem_q[addr_q] <= (op_q == seg_pkg::OP_ERASE)
                                     ? seg_pkg::ERASED_BYTE : data_q[7:0];
                end
            end
        end
    end

    bad_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        (fall_s && !cnt.frame_ok && prog_q == 21'h0) |=> prog_q == 21'h0)
        else $error("programming started on bad count");
    good_launch_a: assert property (@(posedge clk) disable iff (!rst_n)
        accept |=> prog_q == 21'(PROG_CYCLES))
        else $error("accepted frame did not launch cycle");
    read_ungated_a: assert property (@(posedge clk) disable iff (!rst_n)
        (fall_s && op_q == seg_pkg::OP_READ && !busy) |=> !busy)
        else $error("read started programming");
    count_clear_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        !s_sel |=> cnt.count == 5'h00)
        else $error("count not cleared when deselected");
    org_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        (accept && op_q == seg_pkg::OP_WRITE)
        |-> cnt.count == (word ? 5'h19 : 5'h12))
        else $error("write accepted at wrong length");
    start_frame_a: assert property (@(posedge clk) disable iff (!rst_n)
        (start && prog_q == 21'h0) |=> st_q == seg_pkg::SEG_OPCODE)
        else $error("start bit not taken");
    erased_idx_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> mem_q[ridx] == seg_pkg::ERASED_BYTE)
        else $error("array not erased at reset");
    idle_noprog_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!wen_q && fall_s) |=> prog_q == 21'h0 || $past(prog_q) != 21'h0)
        else $error("programming while disabled");
endmodule : seg_eeprom_guard

/* verification/seg_host_model.sv */
`timescale 1ns/1ps
// Host bus master: frames select, serial clock and data in
module seg_host_model (
    input  wire logic clk,
    output logic      sel,
    output logic      sclk,
    output logic      sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    logic oe_seen;  // Output enable at the dummy bit sample
    // Idle: deselected, clock parked low, data line left high
    initial begin
        sel  = 1'b0;
        sclk = 1'b0;
        sdi  = 1'b1;
    end

    // Half a serial clock period, 160 ns
    task automatic half();
        repeat (4) @(negedge clk);
    endtask : half

    // Send n bits of v MSB first, then clock out nrd read bits
    task automatic frame(input logic [31:0] v, input int n, input int nrd,
                         output logic [16:0] rd);
        rd = '0;
        oe_seen = 1'b0;
        @(negedge clk);
        sel = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            sdi = v[i];
            half();
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
        // Let go of the line after the last address bit
        sdi = ~sdi;
        // First sample is the dummy zero, then data bits
        for (int j = 0; j <= nrd && nrd > 0; j++) begin
            half();
            rd = {rd[15:0], sdo};
            if (j == 0)
                oe_seen = sdo_oe;
            if (j < nrd) begin
                sclk = 1'b1;
                half();
                sclk = 1'b0;
            end
        end
        // Select drops before any further rise of the clock
        @(negedge clk);
        sel = 1'b0;
        sdi = ~sdi;
        half();
    endtask : frame
endmodule : seg_host_model

/* verification/seg_eeprom_guard_bench.sv */
`timescale 1ns/1ps
// Pulse count guard bench, short programming time
module seg_eeprom_guard_bench;
    logic clk;        // System clock
    logic rst_n;      // Async reset
    logic org_n_byte; // Width select
    logic sel;        // Chip select from host
    logic sclk;       // Serial clock from host
    logic sdi;        // Serial data from host
    logic sdo;        // Serial data out
    logic sdo_oe;     // Data out enable
    logic busy;       // Programming cycle running
    int   error_cnt;  // Mismatches
    int   n_tests;    // Comparisons

    seg_eeprom_guard #(.PROG_CYCLES(20)) dut (
        .clk(clk), .rst_n(rst_n), .sel(sel), .sclk(sclk), .sdi(sdi),
        .org_n_byte(org_n_byte), .sdo(sdo), .sdo_oe(sdo_oe), .busy(busy)
    );
    seg_host_model host (
        .clk(clk), .sel(sel), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe)
    );

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic report_and_stop();
        if (error_cnt == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [16:0] got, input logic [16:0] exp,
                         input string what);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask : check

    // Busy must rise shortly after select falls when exp is set and stay low otherwise, then clear
    task automatic expect_busy(input logic exp);
        logic seen;
        seen = 1'b0;
        for (int k = 0; k < 20 && !seen; k++) begin
            @(negedge clk);
            seen = (busy === 1'b1);
        end
        check({16'h0000, seen}, {16'h0000, exp}, "busy");
        for (int k = 0; k < 100 && busy !== 1'b0; k++)
            @(negedge clk);
        if (busy !== 1'b0) begin
            error_cnt++;
            report_and_stop();
        end
    endtask : expect_busy

    // One program or mode frame with its busy outcome
    task automatic prog(input logic [31:0] v, input int n, input logic exp);
        logic [16:0] r;
        host.frame(v, n, 0, r);
        expect_busy(exp);
    endtask : prog

    // Read one unit in the current organisation
    task automatic rd_chk(input logic [6:0] a, input logic [16:0] exp);
        logic [16:0] r;
        if (org_n_byte)
            host.frame(32'({1'b1, seg_pkg::OP_READ, a[5:0]}), 9, 16, r);
        else
            host.frame(32'({1'b1, seg_pkg::OP_READ, a}), 10, 8, r);
        check(r, exp, "read");
        check({16'h0000, host.oe_seen}, 17'h0_0001, "oe in read");
        check({16'h0000, sdo_oe}, 17'h0_0000, "oe idle");
    endtask : rd_chk

    // Fresh array in both organisations
    task automatic t_erased();
        org_n_byte = 1'b0;
        rd_chk(7'h05, {9'h000, seg_pkg::ERASED_BYTE});
        org_n_byte = 1'b1;
        rd_chk(7'h02, 17'h0_FFFF);
        org_n_byte = 1'b0;
    endtask : t_erased

    // Byte writes with exact, long and short frames
    task automatic t_byte_write();
        prog(32'({1'b1, seg_pkg::OP_WRITE, 7'h05, 8'h5A}), 18, 1'b0);
        prog(32'({1'b1, seg_pkg::OP_EXT, seg_pkg::SUB_ENABLE, 5'h00}), 10,
             1'b0);
        prog(32'({1'b1, seg_pkg::OP_WRITE, 7'h05, 8'h5A}), 18, 1'b1);
        rd_chk(7'h05, 17'h0_005A);
        prog(32'({1'b1, seg_pkg::OP_WRITE, 7'h05, 8'h00, 1'b0}), 19,
             1'b0);
        prog(32'({1'b1, seg_pkg::OP_WRITE, 7'h05, 7'h00}), 17, 1'b0);
        rd_chk(7'h05, 17'h0_005A);
        prog(32'({1'b1, seg_pkg::OP_WRITE, 7'h05, 8'hC3}), 18, 1'b1);
        rd_chk(7'h05, 17'h0_00C3);
    endtask : t_byte_write

    // Erase, fill-all, erase-all, then disable
    task automatic t_program_set();
        prog(32'({1'b1, seg_pkg::OP_ERASE, 7'h05, 8'h00}), 18, 1'b1);
        rd_chk(7'h05, 17'h0_00FF);
        prog(32'({1'b1, seg_pkg::OP_EXT, seg_pkg::SUB_FILL_ALL, 5'h00,
                  8'h3C}), 18, 1'b1);
        rd_chk(7'h09, 17'h0_003C);
        prog(32'({1'b1, seg_pkg::OP_EXT, seg_pkg::SUB_ERASE_ALL, 5'h00,
                  8'h00}), 18, 1'b1);
        rd_chk(7'h09, 17'h0_00FF);
        prog(32'({1'b1, seg_pkg::OP_EXT, seg_pkg::SUB_DISABLE, 5'h00}), 10,
             1'b0);
        prog(32'({1'b1, seg_pkg::OP_WRITE, 7'h05, 8'h11}), 18, 1'b0);
        rd_chk(7'h05, 17'h0_00FF);
    endtask : t_program_set

    // Word organisation needs 25 pulses
    task automatic t_word();
        org_n_byte = 1'b1;
        prog(32'({1'b1, seg_pkg::OP_EXT, seg_pkg::SUB_ENABLE, 4'h0}), 9,
             1'b0);
        prog(32'({1'b1, seg_pkg::OP_WRITE, 6'h02, 16'hA55A}), 25,
             1'b1);
        rd_chk(7'h02, 17'h0_A55A);
        prog(32'({1'b1, seg_pkg::OP_WRITE, 6'h02, 15'h0000}), 24,
             1'b0);
        prog(32'({1'b1, seg_pkg::OP_WRITE, 6'h02, 16'h0000, 1'b0}), 26,
             1'b0);
        rd_chk(7'h02, 17'h0_A55A);
    endtask : t_word

    // Main sequence
    initial begin
        error_cnt  = 0;
        n_tests    = 0;
        rst_n      = 1'b0;
        org_n_byte = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_erased();
        t_byte_write();
        t_program_set();
        t_word();
        report_and_stop();
    end

    // Guard against a hang
    initial begin
        #3_000_000;
        error_cnt++;
        report_and_stop();
    end
endmodule : seg_eeprom_guard_bench
